// ===== common/rtcb_pkg.sv
// rtcb_pkg: register map, field layout and timing constants of the binary rtc
package rtcb_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_SECONDS = 8'h00;
	localparam logic [7:0] OFF_SUBSEC = 8'h04;
	localparam logic [7:0] OFF_DAY_ALARM = 8'h08;
	localparam logic [7:0] OFF_INTERVAL = 8'h0c;
	localparam logic [7:0] OFF_CONTROL = 8'h10;
	localparam logic [7:0] OFF_TRIM = 8'h14;
	localparam logic [7:0] OFF_OSC_CTRL = 8'h18;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int CTL_ENABLE = 0;
	localparam int CTL_TOD_EN = 1;
	localparam int CTL_SS_EN = 2;
	localparam int CTL_BUSY = 3;
	localparam int CTL_READY = 4;
	localparam int CTL_READY_IE = 5;
	localparam int CTL_TOD_FL = 6;
	localparam int CTL_SS_FL = 7;
	localparam int CTL_CAL_EN = 8;
	localparam int CTL_FSEL_LO = 9;
	localparam int CTL_FSEL_HI = 10;
	localparam int CTL_MODE_LO = 11;
	localparam int CTL_MODE_HI = 12;
	localparam int CTL_WRITE_EN = 15;

	// ----------------------------------------------------------------
	// trim and oscillator control fields
	// ----------------------------------------------------------------
	localparam int TRIM_LO = 0;
	localparam int TRIM_HI = 7;
	localparam int VRTC_LO = 8;
	localparam int VRTC_HI = 31;
	localparam int OSC_BYPASS = 4;
	localparam int OSC_RAW_OUT = 5;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic BUSY_RST = 1'b1;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int ELAPSED_PERIOD_S = 32;
	localparam int ELAPSED_BITS = $clog2(ELAPSED_PERIOD_S);
	localparam logic [6:0] READY_CLR_AT = 7'h78;
	localparam int PPM_SCALE = 1000000;
	localparam logic [1:0] CAL_1K = 2'h0;
	localparam logic [1:0] CAL_512 = 2'h1;

	// ----------------------------------------------------------------
	// bus data-phase carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [5:0] word;
	} rtcb_phase_type;

endpackage : rtcb_pkg

// ===== logic/rtcb_top.sv
// rtcb_top: binary real-time clock with alarms behind an ahb-lite slave
//
// Overview of operation
// - 40-bit time: 8-bit sub-second low part, 32-bit seconds bump on sub-second wrap.
// - once enabled counting runs until disabled; reads never disturb it.
// - elapsed-time field advances once every 32 seconds while running.
// - day alarm fires when alarm value equals seconds bits 19:0.
// - day alarm firing sets the day alarm flag.
// - interrupt whenever day flag set, even by software, if enables allow.
// - writing interval start loads counter; enabling counts up at 256 Hz.
// - interval wrap to zero sets its flag and reloads start value.
// - only first interval may be up to one tick short; later ones exact.
// - start value zero gives full 32-bit interval.
// - busy set on reset, seconds or trim writes, enable changes.
// - while busy, protected bits and count registers ignore writes.
// - busy clears on next 32 kHz edge, within one 4 kHz period.
// - ready clears one 4 kHz period before update, sets after it.
// - ready interrupt enable raises interrupt whenever hardware sets ready, if system interrupt enable is set.
// - clock enable changes need write enable and not busy.
// - calibration output gives raw 4 kHz or trimmed 1 kHz or 512 Hz.
// - select code 01 gives 512 Hz, code 1x gives 4 kHz.
// - without write enable, trim and clock enable writes are ignored.
module rtcb_top
	import rtcb_pkg::*;
#(
	parameter int DAY_ALARM_BITS = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic crystal_in_pin,
	input wire logic sys_int_en,
	output logic irq,
	output logic calibration_output_pin
);

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	if (DAY_ALARM_BITS < 1 || DAY_ALARM_BITS > 32) begin : g_bad_width
		$error("DAY_ALARM_BITS must lie in 1..32");
	end

	function automatic logic hit(input rtcb_phase_type p, input logic [7:0] off);
		hit = p.word == off[7:2];
	endfunction : hit

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	rtcb_phase_type dph_q;
	rtcb_phase_type dph_d;
	logic rd_rdy_q;
	logic wr;
	logic [31:0] rd_mux;
	logic [31:0] control_rd;

	always_comb begin
		dph_d.valid = hsel & htrans[1];
		dph_d.write = hwrite;
		dph_d.word = haddr[7:2];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph_q <= '0;
			rd_rdy_q <= 1'b0;
		end else if (hready) begin
			dph_q <= dph_d.valid ? dph_d : '0;
			rd_rdy_q <= 1'b0;
		end else if (dph_q.valid && !dph_q.write) begin
			rd_rdy_q <= 1'b1;
		end
	end

	// reads take one wait state so that a preceding write is visible
	assign hreadyout = !(dph_q.valid && !dph_q.write && !rd_rdy_q);
	assign hresp = 1'b0;
	assign wr = dph_q.valid && dph_q.write;

	// ----------------------------------------------------------------
	// crystal edge, prescaler and trim
	// ----------------------------------------------------------------
	logic xtal_q;
	logic tick32;
	logic [6:0] presc_q;
	logic [7:0] presc_sum;
	logic tick256;
	logic [2:0] raw_q;
	logic tick4k;
	logic signed [21:0] acc_q;
	logic signed [21:0] acc_sum;
	logic [1:0] step_q;
	logic [7:0] trim_q;

	assign tick32 = crystal_in_pin && !xtal_q;
	assign presc_sum = {1'b0, presc_q} + {6'h00, step_q};
	assign tick256 = tick32 && presc_sum[7];
	assign tick4k = tick32 && (raw_q == 3'h7);
	assign acc_sum = acc_q + 22'(signed'(trim_q));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			xtal_q <= 1'b0;
			raw_q <= '0;
		end else begin
			xtal_q <= crystal_in_pin;
			if (tick32) begin
				raw_q <= raw_q + 3'h1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			presc_q <= '0;
		end else if (tick32) begin
			presc_q <= presc_sum[6:0];
		end
	end

	// ppm trim: add or drop one 32 kHz step per million 4 kHz periods per unit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= '0;
			step_q <= 2'h1;
		end else if (tick4k) begin
			if (acc_sum >= 22'(PPM_SCALE)) begin
				acc_q <= acc_sum - 22'(PPM_SCALE);
				step_q <= 2'h2;
			end else if (acc_sum <= -22'(PPM_SCALE)) begin
				acc_q <= acc_sum + 22'(PPM_SCALE);
				step_q <= 2'h0;
			end else begin
				acc_q <= acc_sum;
				step_q <= 2'h1;
			end
		end else if (tick32) begin
			step_q <= 2'h1;
		end
	end

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic enable_q;
	logic tod_en_q;
	logic ss_en_q;
	logic busy_q;
	logic ready_q;
	logic ready_ie_q;
	logic tod_fl_q;
	logic ss_fl_q;
	logic cal_en_q;
	logic [1:0] fsel_q;
	logic [1:0] mode_q;
	logic write_en_q;
	logic raw_out_q;
	logic bypass_q;
	logic wr_ctl;
	logic en_chg;
	logic tod_chg;
	logic ss_chg;
	logic wr_sec;
	logic wr_trim;
	logic busy_set;
	logic tod_hit;
	logic ss_wrap;

	assign wr_ctl = wr && hit(dph_q, OFF_CONTROL);
	assign en_chg = wr_ctl && !busy_q && write_en_q
		&& (hwdata[CTL_ENABLE] != enable_q);
	assign tod_chg = wr_ctl && !busy_q && (hwdata[CTL_TOD_EN] != tod_en_q);
	assign ss_chg = wr_ctl && !busy_q && (hwdata[CTL_SS_EN] != ss_en_q);
	assign wr_sec = wr && hit(dph_q, OFF_SECONDS) && !busy_q;
	assign wr_trim = wr && hit(dph_q, OFF_TRIM) && !busy_q && write_en_q;

	assign busy_set = en_chg || tod_chg || ss_chg || wr_sec || wr_trim;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= BUSY_RST;
		end else if (busy_set) begin
			busy_q <= 1'b1;
		end else if (tick32) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= 1'b0;
			tod_en_q <= 1'b0;
			ss_en_q <= 1'b0;
		end else begin
			if (en_chg) begin
				enable_q <= hwdata[CTL_ENABLE];
			end
			if (tod_chg) begin
				tod_en_q <= hwdata[CTL_TOD_EN];
			end
			if (ss_chg) begin
				ss_en_q <= hwdata[CTL_SS_EN];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			write_en_q <= 1'b0;
			mode_q <= '0;
			fsel_q <= '0;
			cal_en_q <= 1'b0;
			ready_ie_q <= 1'b0;
		end else if (wr_ctl) begin
			write_en_q <= hwdata[CTL_WRITE_EN];
			mode_q <= hwdata[CTL_MODE_HI:CTL_MODE_LO];
			fsel_q <= hwdata[CTL_FSEL_HI:CTL_FSEL_LO];
			cal_en_q <= hwdata[CTL_CAL_EN];
			ready_ie_q <= hwdata[CTL_READY_IE];
		end
	end

	// alarm flags: hardware set wins over a software write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tod_fl_q <= 1'b0;
			ss_fl_q <= 1'b0;
		end else begin
			if (tod_hit) begin
				tod_fl_q <= 1'b1;
			end else if (wr_ctl) begin
				tod_fl_q <= hwdata[CTL_TOD_FL];
			end
			if (ss_wrap) begin
				ss_fl_q <= 1'b1;
			end else if (wr_ctl) begin
				ss_fl_q <= hwdata[CTL_SS_FL];
			end
		end
	end

	// ready: cleared ahead of the count ripple, set right after it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ready_q <= 1'b0;
		end else if (enable_q && tick256) begin
			ready_q <= 1'b1;
		end else if (enable_q && tick32 && presc_q >= READY_CLR_AT) begin
			ready_q <= 1'b0;
		end else if (wr_ctl && !hwdata[CTL_READY]) begin
			ready_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// time counter and elapsed field
	// ----------------------------------------------------------------
	logic [31:0] sec_q;
	logic [7:0] sub_q;
	logic [23:0] vrtc_q;
	logic count_step;
	logic [31:0] sec_next;

	assign count_step = enable_q && tick256;
	assign sec_next = sec_q + 32'h1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sub_q <= '0;
		end else if (wr && hit(dph_q, OFF_SUBSEC) && !busy_q) begin
			sub_q <= hwdata[7:0];
		end else if (count_step) begin
			sub_q <= sub_q + 8'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sec_q <= '0;
		end else if (wr_sec) begin
			sec_q <= hwdata;
		end else if (count_step && sub_q == 8'hff) begin
			sec_q <= sec_next;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vrtc_q <= '0;
			trim_q <= '0;
		end else if (wr_trim) begin
			vrtc_q <= hwdata[VRTC_HI:VRTC_LO];
			trim_q <= hwdata[TRIM_HI:TRIM_LO];
		end else if (count_step && sub_q == 8'hff
			&& sec_next[ELAPSED_BITS-1:0] == '0) begin
			vrtc_q <= vrtc_q + 24'h1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			raw_out_q <= 1'b0;
			bypass_q <= 1'b0;
		end else if (wr && hit(dph_q, OFF_OSC_CTRL) && !busy_q && write_en_q) begin
			raw_out_q <= hwdata[OSC_RAW_OUT];
			bypass_q <= hwdata[OSC_BYPASS];
		end
	end

	// ----------------------------------------------------------------
	// day alarm
	// ----------------------------------------------------------------
	logic [DAY_ALARM_BITS-1:0] day_q;
	logic match_q;
	logic match_now;

	assign match_now = day_q == sec_q[DAY_ALARM_BITS-1:0];
	assign tod_hit = tod_en_q && match_now && !match_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			day_q <= '0;
			match_q <= 1'b0;
		end else begin
			match_q <= tod_en_q && match_now;
			if (wr && hit(dph_q, OFF_DAY_ALARM)) begin
				day_q <= hwdata[DAY_ALARM_BITS-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// interval alarm
	// ----------------------------------------------------------------
	logic [31:0] start_q;
	logic [31:0] ivl_q;

	assign ss_wrap = ss_en_q && tick256 && ivl_q == 32'hffffffff;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			start_q <= '0;
			ivl_q <= '0;
		end else if (wr && hit(dph_q, OFF_INTERVAL)) begin
			start_q <= hwdata;
			ivl_q <= hwdata;
		end else if (ss_chg && hwdata[CTL_SS_EN]) begin
			ivl_q <= start_q;
		end else if (ss_wrap) begin
			ivl_q <= start_q;
		end else if (ss_en_q && tick256) begin
			ivl_q <= ivl_q + 32'h1;
		end
	end

	// ----------------------------------------------------------------
	// interrupt request and calibration output
	// ----------------------------------------------------------------
	assign irq = sys_int_en && ((tod_fl_q && tod_en_q) || (ss_fl_q && ss_en_q)
		|| (ready_q && ready_ie_q));

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			calibration_output_pin <= 1'b0;
		end else if (raw_out_q) begin
			calibration_output_pin <= crystal_in_pin;
		end else if (!cal_en_q) begin
			calibration_output_pin <= 1'b0;
		end else if (fsel_q[1]) begin
			calibration_output_pin <= raw_q[2];
		end else if (fsel_q == CAL_512) begin
			calibration_output_pin <= presc_q[5];
		end else begin
			calibration_output_pin <= presc_q[4];
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_comb begin
		control_rd = '0;
		control_rd[CTL_ENABLE] = enable_q;
		control_rd[CTL_TOD_EN] = tod_en_q;
		control_rd[CTL_SS_EN] = ss_en_q;
		control_rd[CTL_BUSY] = busy_q;
		control_rd[CTL_READY] = ready_q;
		control_rd[CTL_READY_IE] = ready_ie_q;
		control_rd[CTL_TOD_FL] = tod_fl_q;
		control_rd[CTL_SS_FL] = ss_fl_q;
		control_rd[CTL_CAL_EN] = cal_en_q;
		control_rd[CTL_FSEL_HI:CTL_FSEL_LO] = fsel_q;
		control_rd[CTL_MODE_HI:CTL_MODE_LO] = mode_q;
		control_rd[CTL_WRITE_EN] = write_en_q;
	end

	always_comb begin
		rd_mux = '0;
		if (hit(dph_q, OFF_SECONDS)) begin
			rd_mux = sec_q;
		end else if (hit(dph_q, OFF_SUBSEC)) begin
			rd_mux = {24'h000000, sub_q};
		end else if (hit(dph_q, OFF_DAY_ALARM)) begin
			rd_mux[DAY_ALARM_BITS-1:0] = day_q;
		end else if (hit(dph_q, OFF_INTERVAL)) begin
			rd_mux = start_q;
		end else if (hit(dph_q, OFF_CONTROL)) begin
			rd_mux = control_rd;
		end else if (hit(dph_q, OFF_TRIM)) begin
			rd_mux = {vrtc_q, trim_q};
		end else if (hit(dph_q, OFF_OSC_CTRL)) begin
			rd_mux[OSC_RAW_OUT] = raw_out_q;
			rd_mux[OSC_BYPASS] = bypass_q;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (dph_q.valid && !dph_q.write && !rd_rdy_q) begin
			hrdata <= rd_mux;
		end
	end

endmodule : rtcb_top

// ===== testbench/rtcb_top_chk.sv
// rtcb_top_chk: bus timing, interrupt gating and busy duration checks for rtcb_top
module rtcb_top_chk
	import rtcb_pkg::*;
#(
	parameter int DAY_ALARM_BITS = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic hresp,
	input wire logic crystal_in_pin,
	input wire logic sys_int_en,
	input wire logic irq,
	input wire logic calibration_output_pin
);
	// one 4 khz period in bus clocks
	localparam int BUSY_MAX = 25000;
	logic take;
	logic rd_q;
	logic ctl_q;
	logic unm_q;
	logic [14:0] age_q;
	assign take = hsel & htrans[1] & hready;
	// remembers the read in its data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_q <= 1'b0;
			ctl_q <= 1'b0;
			unm_q <= 1'b0;
		end else begin
			rd_q <= take & !hwrite;
			if (take) begin
				ctl_q <= haddr[7:2] == OFF_CONTROL[7:2];
				unm_q <= haddr[7:2] > 6'h6;
			end
		end
	end
	// cycles since reset or the last write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			age_q <= 15'h0;
		end else if (take & hwrite) begin
			age_q <= 15'h0;
		end else if (age_q != 15'h7fff) begin
			age_q <= age_q + 15'h1;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence s_read_taken;
		take && !hwrite;
	endsequence
	sequence s_wait_one;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	chk_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write data phase stalled");
	chk_read_wait: assert property (s_read_taken |=> s_wait_one)
		else $error("read wait state wrong");
	chk_wait_cause: assert property (!hreadyout |-> rd_q)
		else $error("stall without a read");
	chk_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_q))
		else $error("read data changed outside a read");
	chk_unmapped_zero: assert property (rd_q && unm_q |=> hreadyout && hrdata == 32'h0)
		else $error("unmapped read not zero");
	chk_irq_gate: assert property (!sys_int_en |-> !irq)
		else $error("irq without system enable");
	chk_busy_bound: assert property (rd_q && ctl_q |=> hrdata[CTL_BUSY] |-> age_q <= BUSY_MAX)
		else $error("busy held too long");
endmodule : rtcb_top_chk

bind rtcb_top rtcb_top_chk #(.DAY_ALARM_BITS(DAY_ALARM_BITS)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .crystal_in_pin(crystal_in_pin),
	.sys_int_en(sys_int_en), .irq(irq), .calibration_output_pin(calibration_output_pin)
);

// ===== testbench/tb_binary_rtc_with_alarms.sv
// tb_binary_rtc_with_alarms: self-checking bench for the binary rtc
module tb_binary_rtc_with_alarms
	import rtcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] WE = 32'h1 << CTL_WRITE_EN;
	localparam logic [31:0] EN = 32'h1 << CTL_ENABLE;
	localparam logic [31:0] TOD = 32'h1 << CTL_TOD_EN;
	localparam logic [31:0] SS = 32'h1 << CTL_SS_EN;
	localparam logic [31:0] RIE = 32'h1 << CTL_READY_IE;
	localparam logic [31:0] TFL = 32'h1 << CTL_TOD_FL;
	localparam logic [31:0] BSY = 32'h1 << CTL_BUSY;
	localparam logic [31:0] CAL = 32'h1 << CTL_CAL_EN;
	localparam int SEL[3] = '{2, 1, 0};
	localparam int EXP[3] = '{32, 4, 8};
	logic hclk, hresetn, hsel, hwrite, sys_int_en, xtal;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hreadyout, hresp, irq, cal;
	wire logic [31:0] hrdata;
	int n_fail, checked;
	rtcb_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .crystal_in_pin(xtal),
		.sys_int_en(sys_int_en), .irq(irq), .calibration_output_pin(cal));
	always #5ns hclk = ~hclk;
	// fast crystal: 16 bus clocks a period
	always begin
		repeat (8) @(posedge hclk);
		xtal <= ~xtal;
	end
	task test_done;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : test_done
	task bad(input string m);
		$display("mismatch %0t %s", $time, m);
		n_fail++;
	endtask : bad
	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			bad(m);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask : cyc
	task wt(output logic [31:0] r);
		logic rdy;
		int n;
		rdy = 1'b0;
		n = 0;
		while (!rdy) begin
			@(negedge hclk);
			rdy = hreadyout === 1'b1;
			r = hrdata;
			@(posedge hclk);
			n++;
			if (n > 40) begin
				bad("bus hang");
				test_done();
			end
		end
	endtask : wt
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		logic [31:0] x;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		wt(x);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt(r);
	endtask : bus
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask : rd
	task idle;
		logic [31:0] r;
		int n;
		r = BSY;
		n = 0;
		while (r[CTL_BUSY] !== 1'b0) begin
			rd(OFF_CONTROL, r);
			n++;
			if (n > 20) begin
				bad("busy stuck");
				test_done();
			end
		end
	endtask : idle
	task irq_is(input logic e, input string m);
		@(negedge hclk);
		chk(irq === e, m);
		@(posedge hclk);
	endtask : irq_is
	// waits until just after a crystal rise
	task sync;
		while (xtal !== 1'b0) @(posedge hclk);
		while (xtal !== 1'b1) @(posedge hclk);
	endtask : sync
	task t_reset;
		logic [31:0] r;
		rd(OFF_CONTROL, r);
		chk((r & ~CAL) === BSY, "control at reset");
		idle();
		rd(8'h1c, r);
		chk(r === 32'h0, "unmapped read");
		rd(OFF_DAY_ALARM, r);
		chk(r === 32'h0, "day alarm at reset");
	endtask : t_reset
	task t_count;
		logic [31:0] r, s;
		int n;
		wr(OFF_CONTROL, EN);
		idle();
		rd(OFF_CONTROL, r);
		chk(r[CTL_ENABLE] === 1'b0, "enable without write enable");
		wr(OFF_CONTROL, WE);
		idle();
		sync();
		wr(OFF_TRIM, 32'h5);
		rd(OFF_CONTROL, r);
		chk(r[CTL_BUSY] === 1'b1, "busy after trim write");
		wr(OFF_TRIM, 32'h7);
		idle();
		rd(OFF_TRIM, r);
		chk(r === 32'h5, "trim write while busy");
		wr(OFF_SUBSEC, 32'hfe);
		sync();
		wr(OFF_SECONDS, 32'h1f);
		wr(OFF_SECONDS, 32'h63);
		idle();
		rd(OFF_SECONDS, r);
		chk(r === 32'h1f, "seconds write while busy");
		wr(OFF_DAY_ALARM, 32'h20);
		sys_int_en <= 1'b1;
		wr(OFF_CONTROL, WE | EN | TOD);
		idle();
		n = 0;
		while (r !== 32'h20) begin
			cyc(100);
			rd(OFF_SECONDS, r);
			n++;
			if (n > 90) begin
				bad("seconds stuck");
				test_done();
			end
		end
		rd(OFF_SUBSEC, r);
		chk(r === 32'h0, "subsecond after wrap");
		rd(OFF_TRIM, r);
		chk(r === 32'h105, "elapsed count");
		rd(OFF_CONTROL, r);
		chk(r[CTL_TOD_FL] === 1'b1, "day alarm flag");
		irq_is(1'b1, "day alarm irq");
		wr(OFF_CONTROL, WE | EN | TOD);
		irq_is(1'b0, "flag cleared");
		wr(OFF_CONTROL, WE | EN | TOD | TFL);
		irq_is(1'b1, "software flag irq");
		sys_int_en <= 1'b0;
		irq_is(1'b0, "system enable off");
		sys_int_en <= 1'b1;
		wr(OFF_CONTROL, WE | EN | RIE);
		rd(OFF_CONTROL, r);
		chk(r[CTL_READY] === 1'b0, "ready cleared");
		n = 0;
		while (irq !== 1'b1) begin
			cyc(1);
			n++;
			if (n > 2200) begin
				bad("ready irq missing");
				test_done();
			end
		end
		rd(OFF_CONTROL, r);
		chk(r[CTL_READY] === 1'b1, "ready set");
		sys_int_en <= 1'b0;
		// drop write enable first: the stored bit guards the next write
		wr(OFF_CONTROL, EN);
		wr(OFF_CONTROL, 32'h0);
		idle();
		rd(OFF_CONTROL, r);
		chk(r[CTL_ENABLE] === 1'b1, "enable kept");
		wr(OFF_TRIM, 32'h9);
		rd(OFF_TRIM, r);
		chk(r[7:0] === 8'h05, "trim kept");
		wr(OFF_CONTROL, WE | EN);
		wr(OFF_CONTROL, WE);
		idle();
		rd(OFF_SUBSEC, s);
		cyc(2200);
		rd(OFF_SUBSEC, r);
		chk(r === s, "stopped clock");
	endtask : t_count
	task t_interval;
		logic [31:0] r;
		time t1;
		int i, n;
		wr(OFF_INTERVAL, 32'hffff_fffe);
		rd(OFF_INTERVAL, r);
		chk(r === 32'hffff_fffe, "interval start");
		wr(OFF_CONTROL, WE | SS);
		idle();
		for (i = 0; i < 2; i++) begin
			r = 32'h0;
			n = 0;
			while (r[CTL_SS_FL] !== 1'b1) begin
				rd(OFF_CONTROL, r);
				n++;
				if (n > 2500) begin
					bad("interval flag missing");
					test_done();
				end
			end
			if (i == 1) begin
				chk($time - t1 >= 40920 && $time - t1 <= 41000, "interval period");
			end
			t1 = $time;
			wr(OFF_CONTROL, WE | SS);
		end
		wr(OFF_CONTROL, WE);
		idle();
	endtask : t_interval
	task cnt(output int t);
		logic p;
		t = 0;
		p = cal;
		repeat (2048) begin
			@(posedge hclk);
			if (cal !== p) t++;
			p = cal;
		end
	endtask : cnt
	task t_cal;
		logic [31:0] r;
		int i, t;
		for (i = 0; i < 3; i++) begin
			wr(OFF_CONTROL, WE | CAL | (SEL[i] << CTL_FSEL_LO));
			cyc(1100);
			cnt(t);
			chk(t >= EXP[i] - 1 && t <= EXP[i] + 1, "cal rate");
		end
		wr(OFF_CONTROL, WE);
		cyc(20);
		cnt(t);
		chk(t == 0 && cal === 1'b0, "cal off");
		wr(OFF_OSC_CTRL, 32'h20);
		rd(OFF_OSC_CTRL, r);
		chk(r === 32'h20, "osc control");
		cyc(20);
		cnt(t);
		chk(t >= 255 && t <= 257, "raw crystal out");
	endtask : t_cal
	initial begin
		#900us;
		bad("timeout");
		test_done();
	end
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		sys_int_en = 1'b0;
		xtal = 1'b0;
		n_fail = 0;
		checked = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_count();
		t_interval();
		t_cal();
		test_done();
	end
endmodule : tb_binary_rtc_with_alarms
